// ===== design/stb_pkg.sv
// Constants and register map of the 16-bit timer with capture/compare time base
//
// What this block does
// - Sleep counting only async external pin or oscillator
// - Overflow in sleep wakes; interrupt needs global enable
// - Timer oscillator runs in sleep regardless sync
// - Capture copies count into capture/compare pair
// - Compare event when count equals compare pair
// - Conversion trigger clears count; compare is period
// - Trigger clear never sets overflow flag
// - Count write beats a simultaneous trigger clear
// - Gate falling edge clears arm, sets gate flag
// - Clock source code 11 rejected as reserved
// - Code 10: pin rising edge or crystal oscillator
// - Prescale codes divide by 1, 2, 4, 8
// - Oscillator enable bit switches the oscillator circuit
// - Sync bypass zero synchronises external input
// - Control bit 1 reads zero; bit 0 timer_on
// - Count rolls over to zero, sets overflow_flag
// - Gate falling edge sets flag even ungated
package stb_pkg;
  // Register byte offsets
  localparam logic [7:0] STB_OFS_CONTROL = 8'h00;
  localparam logic [7:0] STB_OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] STB_OFS_COUNT_HIGH = 8'h08;
  localparam logic [7:0] STB_OFS_CC_LOW = 8'h0c;
  localparam logic [7:0] STB_OFS_CC_HIGH = 8'h10;
  localparam logic [7:0] STB_OFS_STATUS = 8'h14;
  localparam logic [7:0] STB_OFS_CCP_MODE = 8'h18;
  localparam logic [7:0] STB_OFS_GATE = 8'h1c;
  // Control field positions
  localparam int STB_CS_HI = 7;
  localparam int STB_CS_LO = 6;
  localparam int STB_PS_HI = 5;
  localparam int STB_PS_LO = 4;
  localparam int STB_OSCEN_BIT = 3;
  localparam int STB_SYNCBP_BIT = 2;
  localparam int STB_ON_BIT = 0;
  localparam logic [7:0] STB_CONTROL_RST = 8'h00;
  localparam logic [7:0] STB_CONTROL_MASK = 8'hfd;
  // Clock source codes
  localparam logic [1:0] STB_CS_INSTR = 2'h0;
  localparam logic [1:0] STB_CS_SYSTEM = 2'h1;
  localparam logic [1:0] STB_CS_EXTERNAL = 2'h2;
  localparam logic [1:0] STB_CS_RESERVED = 2'h3;
  // Status bits, write one to clear
  localparam int STB_ST_OVF_BIT = 0;
  localparam int STB_ST_GATE_BIT = 1;
  localparam int STB_ST_CMP_BIT = 2;
  localparam int STB_ST_CAP_BIT = 3;
  // Gate register bits
  localparam int STB_GT_ARM_BIT = 0;
  localparam int STB_GT_LEVEL_BIT = 1;
  // Instruction clock ticks when the divider reaches this: the system clock divided by four
  localparam logic [1:0] STB_INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] STB_COUNT_MAX = 16'hffff;
  // Capture/compare channel modes
  typedef enum logic [1:0] {
    STB_CCP_OFF,
    STB_CCP_CAPTURE,
    STB_CCP_COMPARE,
    STB_CCP_TRIGGER
  } stb_ccp_mode_t;
endpackage : stb_pkg

// ===== design/stb_timer.sv
// 16-bit timer/counter with prescaler, sleep counting and capture/compare time base
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module stb_timer
  import stb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_mode,
  input wire logic ext_clock_pin,
  input wire logic crystal_osc_pins,
  input wire logic gate_level,
  input wire logic capture_event,
  input wire logic overflow_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  output logic [15:0] count_value,
  output logic compare_event,
  output logic conversion_trigger,
  output logic osc_running,
  output logic wake_up,
  output logic isr_request
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Offsets reach 0x1c, so five address bits at least; haddr gives 32 at most
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
    $error("stb_timer: ADDR_W must lie between 5 and 32");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [15:0] cc;
    stb_ccp_mode_t ccp_mode;
    logic ovf;
    logic gate_flag;
    logic cmp_flag;
    logic cap_flag;
    logic arm;
    logic gate_prev;
    logic [1:0] instr_div;
    logic [2:0] prescale;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_raw;
    logic osc_prev;
    logic cmp_prev;
    logic dp_write;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic [15:0] count_out;
    logic cmp_pulse;
    logic trig_pulse;
    logic osc_run;
    logic wake;
    logic isr;
  } stb_state_t;

  stb_state_t state_ff;
  stb_state_t nxt_state;

  // Prescale code to terminal count of the prescale counter
  function automatic logic [2:0] stb_ps_last(input logic [1:0] code);
    logic [2:0] last;
    last = 3'h0;
    case (code)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
    return last;
  endfunction : stb_ps_last

  // Word-aligned address match
  function automatic logic stb_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction : stb_hit

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [1:0] cs;
    logic sync_bp;
    logic timer_on;
    logic osc_en;
    logic sys_tick;
    logic ext_edge;
    logic src_tick;
    logic may_count;
    logic inc;
    logic trig;
    logic match;
    logic wr_cnt;
    logic gate_fall;
    logic ovf_set;
    logic addr_ok;
    logic [7:0] wctl;
    logic [ADDR_W-1:0] ra;
    logic [31:0] rd;
    nxt_state = state_ff;
    cs = state_ff.control[STB_CS_HI:STB_CS_LO];
    sync_bp = state_ff.control[STB_SYNCBP_BIT];
    timer_on = state_ff.control[STB_ON_BIT];
    osc_en = state_ff.control[STB_OSCEN_BIT];
    sys_tick = 1'b0;
    ext_edge = 1'b0;
    src_tick = 1'b0;
    may_count = 1'b0;
    inc = 1'b0;
    trig = 1'b0;
    match = 1'b0;
    wr_cnt = 1'b0;
    gate_fall = 1'b0;
    ovf_set = 1'b0;
    addr_ok = 1'b0;
    wctl = 8'h00;
    ra = '0;
    rd = 32'h0000_0000;

    // Instruction clock enable: one pulse every fourth system clock
    nxt_state.instr_div = state_ff.instr_div + 2'h1;

    // External input: synchroniser chain, or one raw sample when bypassed
    nxt_state.ext_s1 = ext_clock_pin;
    nxt_state.ext_s2 = state_ff.ext_s1;
    nxt_state.ext_s3 = state_ff.ext_s2;
    nxt_state.ext_raw = ext_clock_pin;
    nxt_state.osc_prev = crystal_osc_pins;

    // Oscillator circuit follows its enable only, never the sync setting
    nxt_state.osc_run = osc_en;

    // Select the counting source
    case (cs)
      STB_CS_INSTR: src_tick = state_ff.instr_div == STB_INSTR_DIV_LAST;
      STB_CS_SYSTEM: src_tick = 1'b1;
      STB_CS_EXTERNAL: begin
        if (osc_en) begin
          ext_edge = crystal_osc_pins & ~state_ff.osc_prev;
        end else if (sync_bp) begin
          ext_edge = ext_clock_pin & ~state_ff.ext_raw;
        end else begin
          ext_edge = state_ff.ext_s2 & ~state_ff.ext_s3;
        end
        src_tick = ext_edge;
      end
      default: src_tick = 1'b0;
    endcase

    // In sleep only the unsynchronised external source keeps counting
    may_count = timer_on & (~sleep_mode | (cs == STB_CS_EXTERNAL & sync_bp));

    // Prescaler divides the selected source
    if (!timer_on) begin
      nxt_state.prescale = 3'h0;
    end else if (may_count && src_tick) begin
      if (state_ff.prescale >= stb_ps_last(state_ff.control[STB_PS_HI:STB_PS_LO])) begin
        nxt_state.prescale = 3'h0;
        sys_tick = 1'b1;
      end else begin
        nxt_state.prescale = state_ff.prescale + 3'h1;
      end
    end
    inc = sys_tick;

    // Compare match, taken once on entering equality
    match = state_ff.count == state_ff.cc;
    nxt_state.cmp_prev = match;
    nxt_state.cmp_pulse = 1'b0;
    nxt_state.trig_pulse = 1'b0;
    if ((state_ff.ccp_mode == STB_CCP_COMPARE || state_ff.ccp_mode == STB_CCP_TRIGGER) && match && !state_ff.cmp_prev) begin
      nxt_state.cmp_pulse = 1'b1;
      nxt_state.cmp_flag = 1'b1;
      trig = state_ff.ccp_mode == STB_CCP_TRIGGER;
      nxt_state.trig_pulse = trig;
    end

    // Capture copies the live count
    if (state_ff.ccp_mode == STB_CCP_CAPTURE && capture_event) begin
      nxt_state.cc = state_ff.count;
      nxt_state.cap_flag = 1'b1;
    end

    // Counting; a trigger clear wins over the increment and never flags overflow
    if (trig) begin
      nxt_state.count = 16'h0000;
    end else if (inc) begin
      nxt_state.count = state_ff.count + 16'h0001;
      ovf_set = state_ff.count == STB_COUNT_MAX;
    end

    // Gate falling edge ends a single pulse and flags the event
    nxt_state.gate_prev = gate_level;
    gate_fall = state_ff.gate_prev & ~gate_level;
    if (gate_fall) begin
      nxt_state.arm = 1'b0;
    end

    // ****************************************
    // Bus data phase: writes
    // ****************************************
    if (state_ff.dp_write) begin
      if (stb_hit(state_ff.dp_addr, STB_OFS_CONTROL)) begin
        wctl = hwdata[7:0] & STB_CONTROL_MASK;
        if (wctl[STB_CS_HI:STB_CS_LO] == STB_CS_RESERVED) begin
          wctl[STB_CS_HI:STB_CS_LO] = cs;
        end
        nxt_state.control = wctl;
      end
      // Software writes beat the trigger clear
      if (stb_hit(state_ff.dp_addr, STB_OFS_COUNT_LOW)) begin
        nxt_state.count[7:0] = hwdata[7:0];
        wr_cnt = 1'b1;
      end
      if (stb_hit(state_ff.dp_addr, STB_OFS_COUNT_HIGH)) begin
        nxt_state.count[15:8] = hwdata[7:0];
        wr_cnt = 1'b1;
      end
      if (wr_cnt && trig) begin
        nxt_state.count[15:8] = stb_hit(state_ff.dp_addr, STB_OFS_COUNT_HIGH) ? hwdata[7:0] : 8'h00;
        nxt_state.count[7:0] = stb_hit(state_ff.dp_addr, STB_OFS_COUNT_LOW) ? hwdata[7:0] : 8'h00;
      end
      if (stb_hit(state_ff.dp_addr, STB_OFS_CC_LOW)) begin
        nxt_state.cc[7:0] = hwdata[7:0];
      end
      if (stb_hit(state_ff.dp_addr, STB_OFS_CC_HIGH)) begin
        nxt_state.cc[15:8] = hwdata[7:0];
      end
      if (stb_hit(state_ff.dp_addr, STB_OFS_CCP_MODE)) begin
        nxt_state.ccp_mode = stb_ccp_mode_t'(hwdata[1:0]);
      end
      // Write one to clear; a flag set in the same cycle survives
      if (stb_hit(state_ff.dp_addr, STB_OFS_STATUS)) begin
        if (hwdata[STB_ST_OVF_BIT]) begin
          nxt_state.ovf = 1'b0;
        end
        if (hwdata[STB_ST_GATE_BIT]) begin
          nxt_state.gate_flag = 1'b0;
        end
        if (hwdata[STB_ST_CMP_BIT]) begin
          nxt_state.cmp_flag = nxt_state.cmp_pulse;
        end
        if (hwdata[STB_ST_CAP_BIT]) begin
          nxt_state.cap_flag = state_ff.ccp_mode == STB_CCP_CAPTURE && capture_event;
        end
      end
      // Arm is set by software only; hardware clears it
      if (stb_hit(state_ff.dp_addr, STB_OFS_GATE) && hwdata[STB_GT_ARM_BIT] && !gate_fall) begin
        nxt_state.arm = 1'b1;
      end
    end
    if (ovf_set) begin
      nxt_state.ovf = 1'b1;
    end
    if (gate_fall) begin
      nxt_state.gate_flag = 1'b1;
    end

    // ****************************************
    // Bus address phase
    // ****************************************
    addr_ok = hsel & hready & htrans[1] & (hsize == 3'h2);
    nxt_state.dp_write = addr_ok & hwrite;
    nxt_state.dp_addr = haddr[ADDR_W-1:0];
    nxt_state.ready = 1'b1;
    ra = haddr[ADDR_W-1:0];
    // Read from the next state so a write just ahead is seen
    if (stb_hit(ra, STB_OFS_CONTROL)) begin
      rd[7:0] = nxt_state.control;
    end else if (stb_hit(ra, STB_OFS_COUNT_LOW)) begin
      rd[7:0] = nxt_state.count[7:0];
    end else if (stb_hit(ra, STB_OFS_COUNT_HIGH)) begin
      rd[7:0] = nxt_state.count[15:8];
    end else if (stb_hit(ra, STB_OFS_CC_LOW)) begin
      rd[7:0] = nxt_state.cc[7:0];
    end else if (stb_hit(ra, STB_OFS_CC_HIGH)) begin
      rd[7:0] = nxt_state.cc[15:8];
    end else if (stb_hit(ra, STB_OFS_STATUS)) begin
      rd[STB_ST_OVF_BIT] = nxt_state.ovf;
      rd[STB_ST_GATE_BIT] = nxt_state.gate_flag;
      rd[STB_ST_CMP_BIT] = nxt_state.cmp_flag;
      rd[STB_ST_CAP_BIT] = nxt_state.cap_flag;
    end else if (stb_hit(ra, STB_OFS_CCP_MODE)) begin
      rd[1:0] = nxt_state.ccp_mode;
    end else if (stb_hit(ra, STB_OFS_GATE)) begin
      rd[STB_GT_ARM_BIT] = nxt_state.arm;
      rd[STB_GT_LEVEL_BIT] = gate_level;
    end
    // Unmapped or write addresses read as zero
    nxt_state.rdata = (addr_ok && !hwrite) ? rd : 32'h0000_0000;

    // ****************************************
    // Outputs
    // ****************************************
    nxt_state.count_out = nxt_state.count;
    // Wake on an overflow in sleep when the peripheral enables are set
    nxt_state.wake = ovf_set & sleep_mode & overflow_irq_enable & peripheral_irq_enable;
    // Service routine only with the global enable as well
    nxt_state.isr = nxt_state.ovf & overflow_irq_enable & peripheral_irq_enable & global_irq_enable;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '{control: STB_CONTROL_RST, ccp_mode: STB_CCP_OFF, dp_addr: '0, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register, except hresp tied to zero
  assign hrdata = state_ff.rdata;
  assign hreadyout = state_ff.ready;
  assign hresp = 1'b0;
  assign count_value = state_ff.count_out;
  assign compare_event = state_ff.cmp_pulse;
  assign conversion_trigger = state_ff.trig_pulse;
  assign osc_running = state_ff.osc_run;
  assign wake_up = state_ff.wake;
  assign isr_request = state_ff.isr;

endmodule : stb_timer
`default_nettype wire

// ===== test/stb_clk_source.sv
// Far-side clock source: external clock pin and timer crystal
`timescale 1ns/1ps
`default_nettype none
module stb_clk_source #(
  parameter int HALF = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_run,
  input wire logic osc_on,
  output logic ext_clock_pin,
  output logic crystal_osc_pins
);
  int cnt_ff;
  // ****
  // Clocks
  // ****
  // Pin clock stands low outside bursts; crystal swings only while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 0;
      ext_clock_pin <= 1'b0;
      crystal_osc_pins <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == HALF - 1) begin
        ext_clock_pin <= pin_run && !ext_clock_pin;
        crystal_osc_pins <= osc_on && !crystal_osc_pins;
      end
    end
  end
endmodule : stb_clk_source
`default_nettype wire

// ===== test/stb_timer_monitor.sv
// Port checker for the timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module stb_timer_monitor
  import stb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sleep_mode,
  input wire logic global_irq_enable,
  input wire logic [15:0] count_value,
  input wire logic compare_event,
  input wire logic conversion_trigger,
  input wire logic osc_running,
  input wire logic wake_up,
  input wire logic isr_request
);
  logic aph_ff;
  logic [7:0] adr_ff;
  logic [7:0] ctl_ff;
  logic cnt_wr;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****
  // Bus shadow
  // ****
  // Software count writes must not be taken for counting faults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= 1'b0;
      adr_ff <= 8'h00;
      ctl_ff <= 8'h00;
    end else begin
      aph_ff <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      adr_ff <= haddr[7:0];
      if (aph_ff && adr_ff == STB_OFS_CONTROL) begin
        ctl_ff[5:0] <= hwdata[5:0] & 6'h3d;
        if (hwdata[7:6] != STB_CS_RESERVED) ctl_ff[7:6] <= hwdata[7:6];
      end
    end
  end
  assign cnt_wr = aph_ff && (adr_ff == STB_OFS_COUNT_LOW || adr_ff == STB_OFS_COUNT_HIGH);
  // ****
  // Checks
  // ****
  a_ready_nowait: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_sleep_freeze: assert property (
    sleep_mode && !cnt_wr && !(ctl_ff[7:6] == STB_CS_EXTERNAL && ctl_ff[2]) |=> $stable(count_value))
    else $error("count moved in sleep");
  a_wake_pulse: assert property (wake_up |-> $past(sleep_mode) ##1 !wake_up)
    else $error("bad wake pulse");
  a_isr_gating: assert property (isr_request |-> $past(global_irq_enable))
    else $error("isr without global enable");
  a_compare_single: assert property (compare_event |=> !compare_event)
    else $error("compare pulse too long");
  a_trigger_clear: assert property (
    conversion_trigger && !$past(cnt_wr) |-> count_value == 16'h0000 && compare_event)
    else $error("trigger did not clear count");
  a_count_step: assert property (
    $changed(count_value) && !$past(cnt_wr) |-> count_value == $past(count_value) + 16'h0001 || conversion_trigger)
    else $error("count jumped");
  a_instr_rate: assert property (
    $changed(count_value) && ctl_ff[7:4] == 4'h0 && !$past(cnt_wr) && !conversion_trigger
    |=> ($stable(count_value) || $past(cnt_wr) || conversion_trigger)[*3])
    else $error("instruction clock too fast");
  a_osc_follow: assert property (osc_running == $past(ctl_ff[3]))
    else $error("oscillator enable not followed");
endmodule : stb_timer_monitor
bind stb_timer stb_timer_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .global_irq_enable(global_irq_enable),
  .count_value(count_value), .compare_event(compare_event), .conversion_trigger(conversion_trigger),
  .osc_running(osc_running), .wake_up(wake_up), .isr_request(isr_request));
`default_nettype wire

// ===== test/stb_timer_tb.sv
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module stb_timer_tb
  import stb_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, lfsr = 32'hd5ca188d;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, ext_clock_pin, crystal_osc_pins, compare_event, conversion_trigger;
  logic osc_running, wake_up, isr_request, sleep_mode = 1'b0, gate_level = 1'b0, capture_event = 1'b0;
  logic ovf_ie = 1'b0, per_ie = 1'b0, glb_ie = 1'b0, pin_run = 1'b0;
  logic [15:0] count_value, c0;
  logic [2:0] evs;
  logic [7:0] v;
  // Config word: expected steps, sleep, control byte
  logic [15:0] cfg [14] = '{16'h1081, 16'h1085, 16'h1089, 16'h118d, 16'h1185, 16'h0181, 16'h0141,
    16'h8041, 16'h4051, 16'h2061, 16'h1071, 16'h2001, 16'h0431, 16'h0891};
  int mismatches = 0, checked = 0, cycles = 0, n, p;
  assign evs = {conversion_trigger, compare_event, wake_up};
  stb_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .ext_clock_pin(ext_clock_pin),
    .crystal_osc_pins(crystal_osc_pins), .gate_level(gate_level), .capture_event(capture_event),
    .overflow_irq_enable(ovf_ie), .peripheral_irq_enable(per_ie), .global_irq_enable(glb_ie),
    .count_value(count_value), .compare_event(compare_event), .conversion_trigger(conversion_trigger),
    .osc_running(osc_running), .wake_up(wake_up), .isr_request(isr_request));
  stb_clk_source src (.hclk(hclk), .hresetn(hresetn), .pin_run(pin_run), .osc_on(osc_running),
    .ext_clock_pin(ext_clock_pin), .crystal_osc_pins(crystal_osc_pins));
  // ****
  // Helpers
  // ****
  always #25 hclk = ~hclk;
  // Hang guard, well above the whole sequence
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Single word transfer; holds each phase until ready is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic wait_ev(input int k);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (evs[k] !== 1'b1 && n < 999);
    chk(n < 999, 1);
  endtask : wait_ev
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ****
  // Sequence
  // ****
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(STB_OFS_CONTROL, 32'h0);
    rdc(8'hfc, 32'h0);
    wr(STB_OFS_CONTROL, 32'hff);
    rdc(STB_OFS_CONTROL, 32'h3d);
    wr(STB_OFS_CONTROL, 32'h82);
    rdc(STB_OFS_CONTROL, 32'h80);
    $display("registers done");
    // Each source, prescale and sleep case over a 64-cycle window
    foreach (cfg[i]) begin
      wr(STB_OFS_CONTROL, 32'h0);
      lfsr = lfsr_next(lfsr);
      wr(STB_OFS_COUNT_LOW, lfsr);
      wr(STB_OFS_COUNT_HIGH, lfsr >> 8);
      sleep_mode <= cfg[i][8];
      pin_run <= !cfg[i][3];
      wr(STB_OFS_CONTROL, {24'h0, cfg[i][7:0]});
      repeat (16) @(posedge hclk);
      c0 = count_value;
      repeat (64) @(posedge hclk);
      chk(16'(count_value - c0), cfg[i][15:9]);
    end
    $display("sources done");
    wr(STB_OFS_CONTROL, 32'h0);
    wr(STB_OFS_STATUS, 32'hf);
    wr(STB_OFS_COUNT_LOW, 32'hfe);
    wr(STB_OFS_COUNT_HIGH, 32'hff);
    ovf_ie <= 1'b1;
    per_ie <= 1'b1;
    sleep_mode <= 1'b1;
    pin_run <= 1'b1;
    wr(STB_OFS_CONTROL, 32'h85);
    wait_ev(0);
    chk(isr_request, 0);
    rdc(STB_OFS_STATUS, 32'h1);
    glb_ie <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(isr_request, 1);
    wr(STB_OFS_STATUS, 32'h1);
    repeat (2) @(posedge hclk);
    chk(isr_request, 0);
    sleep_mode <= 1'b0;
    pin_run <= 1'b0;
    $display("wake done");
    lfsr = lfsr_next(lfsr);
    wr(STB_OFS_CONTROL, 32'h0);
    wr(STB_OFS_COUNT_LOW, lfsr);
    wr(STB_OFS_COUNT_HIGH, lfsr >> 8);
    wr(STB_OFS_CCP_MODE, 32'h1);
    capture_event <= 1'b1;
    @(posedge hclk);
    capture_event <= 1'b0;
    @(posedge hclk);
    rdc(STB_OFS_CC_LOW, lfsr[7:0]);
    rdc(STB_OFS_CC_HIGH, lfsr[15:8]);
    $display("capture done");
    // Trigger period, then a count write landing on the trigger edge
    p = 8 + int'(lfsr[3:0]);
    v = {1'b1, lfsr[14:8]};
    for (int m = 3; m >= 2; m--) begin
      wr(STB_OFS_CONTROL, 32'h0);
      wr(STB_OFS_CC_LOW, p);
      wr(STB_OFS_CC_HIGH, 32'h0);
      wr(STB_OFS_COUNT_LOW, 32'h0);
      wr(STB_OFS_COUNT_HIGH, 32'h0);
      wr(STB_OFS_STATUS, 32'hf);
      wr(STB_OFS_CCP_MODE, m);
      wr(STB_OFS_CONTROL, 32'h1);
      wait_ev(m - 1);
      if (m == 3) begin
        wait_ev(2);
        chk(n, 4 * p);
        rdc(STB_OFS_STATUS, 32'h4);
        // Clear the compare flag, then clear it again on the trigger edge: the set must win
        wait_ev(2);
        wr(STB_OFS_STATUS, 32'h4);
        repeat (4 * p - 5) @(posedge hclk);
        wr(STB_OFS_STATUS, 32'h4);
        rdc(STB_OFS_STATUS, 32'h4);
        wait_ev(2);
        repeat (4 * p - 3) @(posedge hclk);
        wr(STB_OFS_COUNT_LOW, v);
        #1;
        chk(count_value, v);
        chk(conversion_trigger, 1);
        @(posedge hclk);
      end else begin
        chk(conversion_trigger, 0);
        repeat (8) @(posedge hclk);
        chk(count_value, p + 2);
      end
    end
    $display("compare done");
    wr(STB_OFS_CONTROL, 32'h0);
    wr(STB_OFS_STATUS, 32'hf);
    wr(STB_OFS_GATE, 32'h1);
    gate_level <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(STB_OFS_GATE, 32'h3);
    gate_level <= 1'b0;
    repeat (4) @(posedge hclk);
    rdc(STB_OFS_GATE, 32'h0);
    rdc(STB_OFS_STATUS, 32'h2);
    $display("gate done");
    end_of_test();
  end
endmodule : stb_timer_tb
`default_nettype wire
